// File: design/osw_pkg.sv
package osw_pkg;

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CTRL1_WIN_REQ_BIT = 0;
  localparam int CTRL1_VFUNC_BIT = 5;
  localparam int CTRL2_HFUNC_BIT = 4;
  localparam int CTRL2_HBLANK_BIT = 5;
  localparam int CTRL2_VBLANK_BIT = 6;
  localparam int CTRL2_LAYER_BIT = 7;
  localparam int CTRL3_CAPTION_BIT = 5;
  localparam int CTRL3_GENERAL_BIT = 6;
  localparam int CTRL3_DOT_BIT = 7;

  // ----------------------------------------------------------------
  // Raster colour register layout
  // ----------------------------------------------------------------
  localparam int RAS_RED_BIT = 0;
  localparam int RAS_O2_BIT = 4;
  localparam int RAS_SYNC_BIT = 5;
  localparam int RAS_ON_BIT = 6;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DOT_W = 12;
  localparam int LINE_W = 10;
  localparam int HPOS_W = 11;
  localparam int VPOS_W = 10;
  localparam int EDGE_H_W = 10;
  localparam int EDGE_H_SHIFT = 2;
  localparam int BLK_H_W = 6;
  localparam int SPR_COL_W = 5;
  localparam int SPR_ROW_W = 5;
  localparam int SPR_ADDR_W = 10;
  localparam int SPR_DEPTH = 640;
  localparam int SPR_DOT_BITS = 4;
  localparam int PAL_ENTRIES = 16;
  localparam int PAL_W = 4;
  localparam logic [DOT_W-1:0] SPR_W_DOTS = 12'h020;
  localparam logic [VPOS_W-1:0] SPR_H_LINES = 10'h014;
  localparam logic [SPR_DOT_BITS-1:0] SPR_CLEAR_DOT = 4'h0;

  // ----------------------------------------------------------------
  // Character display modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CAPTION = 2'b00,
    MODE_GENERAL = 2'b01,
    MODE_DOT = 2'b10
  } osw_mode_e;

endpackage : osw_pkg

// File: design/osw_sync2.sv
`timescale 1ns/1ps
module osw_sync2 #(
  parameter int W = 2
) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Async reset, low
  input wire logic [W-1:0] asyncIn, // Pin levels
  output logic [W-1:0] syncOut // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : osw_sync2

// File: design/osw_sprite_ram.sv
`timescale 1ns/1ps
module osw_sprite_ram #(
  parameter int DW = 4,
  parameter int AW = 10,
  parameter int DEPTH = 640
) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Async reset, low
  input wire logic wrEn, // Write strobe
  input wire logic [AW-1:0] wrAddr, // Write address
  input wire logic [DW-1:0] wrData, // Write data
  input wire logic [AW-1:0] rdAddr, // Read address
  output logic [DW-1:0] rdData_q // Read data, one cycle late
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wrEn && (int'(wrAddr) < DEPTH)) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Out-of-range reads give a clear dot
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= '0;
    end else if (int'(rdAddr) < DEPTH) begin
      rdData_q <= mem[rdAddr];
    end else begin
      rdData_q <= '0;
    end
  end
endmodule : osw_sprite_ram

// File: design/osw_top.sv
// Overview of operation
// - Block shows from its start line; block-end fires once scan leaves it.
// - Control 2 bit 7 picks layer 1 or layer 2 for block-end.
// - Blocks switched off never raise block-end.
// - Overlapping blocks give one block-end, at the end of the later.
// - Caption blocks hidden by the window still raise block-end.
// - Two writable sprites, 32 by 20 dots, four bits per dot.
// - Each non-clear sprite dot picks one of palette entries 1 to 15; dot value 0 is clear.
// - Sprite position free: 2048 steps of 2 clocks, 1024 lines.
// - A sprite interrupt fires when a sprite finishes; two ending together give one.
// - Sprites win over OSD but never drive or mask second overlay.
// - Overlapping sprites: larger vertical start wins; tie shows sprite 1.
// - Control bits enable vertical, horizontal functions and pick window/blank.
// - Enabled window limits OSD output to the edge rectangle.
// - Control 3 bits 7:5 pick windowed modes; second overlay always windowed.
// - Sprites ignore the window.
// - Blank output outside rectangle; lines vertically, four clocks horizontally.
// - In blanked area characters still show but raster is removed.
// - No blank output during sync blanking intervals.
// - Raster register bits switch each colour output to raster colour.
// - Character colour fully replaces raster colour where they overlap.
`timescale 1ns/1ps
module osw_top #(
  parameter int NBLK = 16,
  parameter int VPW = osw_pkg::VPOS_W,
  parameter int HPW = osw_pkg::HPOS_W
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic resetn, // Async reset, low
  input wire logic hsyncPin, // Horizontal sync pin
  input wire logic vsyncPin, // Vertical sync pin
  input wire logic [7:0] ctrl1, // OSD control 1
  input wire logic [7:0] ctrl2, // OSD control 2
  input wire logic [7:0] ctrl3, // OSD control 3
  input wire logic [6:0] rasterColor, // Raster colour switches
  input wire logic [VPW-1:0] topEdgeReg, // Top edge, lines
  input wire logic [VPW-1:0] bottomEdgeReg, // Bottom edge, lines
  input wire logic [9:0] leftEdgeReg, // Left edge, 4-clock units
  input wire logic [9:0] rightEdgeReg, // Right edge, 4-clock units
  input wire logic [NBLK-1:0] blkOn, // Block display-control bits
  input wire logic [NBLK-1:0] blkLayer, // Block layer, 1 = layer 2
  input wire logic [NBLK*VPW-1:0] blkVpos, // Block start lines
  input wire logic [NBLK*6-1:0] blkHeight, // Block heights, lines
  input wire logic charVis, // Character or background pixel
  input wire logic [3:0] charColor, // Char {O1,B,G,R}
  input wire logic charO2, // Char second overlay
  input wire logic [1:0] charMode, // Char display mode
  input wire logic [1:0] sprEnable, // Sprite enables
  input wire logic [HPW-1:0] spriteHpos1, // Sprite 1 column
  input wire logic [HPW-1:0] spriteHpos2, // Sprite 2 column
  input wire logic [VPW-1:0] spriteVpos1, // Sprite 1 line
  input wire logic [VPW-1:0] spriteVpos2, // Sprite 2 line
  input wire logic [63:0] paletteFlat, // 16 palette entries
  input wire logic sprWrEn, // Sprite RAM write
  input wire logic sprWrSel, // Sprite RAM select
  input wire logic [9:0] sprWrAddr, // Sprite dot address
  input wire logic [3:0] sprWrData, // Sprite dot data
  input wire logic blockEndClr, // Clear block-end flag
  input wire logic spriteClr, // Clear sprite flag
  output logic redOut, // Red
  output logic greenOut, // Green
  output logic blueOut, // Blue
  output logic blankOverlayOut, // First overlay / blank
  output logic secondOverlayOut, // Second overlay
  output logic blockEndIrq, // Block-end pulse
  output logic spriteIrq, // Sprite-end pulse
  output logic blockEndPend, // Block-end flag
  output logic spritePend // Sprite flag
);
  localparam int DW = osw_pkg::DOT_W;
  localparam int LW = osw_pkg::LINE_W;

  // ----------------------------------------------------------------
  // Scan counters
  // ----------------------------------------------------------------
  logic [1:0] syncLv;
  logic hsS, vsS, hsPrev_q, vsPrev_q, hsRise, vsRise, inBlanking;
  logic [DW-1:0] dotCnt_q;
  logic [LW-1:0] lineCnt_q;

  osw_sync2 #(.W(2)) uSync (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn({vsyncPin, hsyncPin}),
    .syncOut(syncLv)
  );

  assign hsS = syncLv[0];
  assign vsS = syncLv[1];
  assign hsRise = hsS && !hsPrev_q;
  assign vsRise = vsS && !vsPrev_q;
  assign inBlanking = hsS || vsS;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hsPrev_q <= 1'b0;
      vsPrev_q <= 1'b0;
    end else begin
      hsPrev_q <= hsS;
      vsPrev_q <= vsS;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dotCnt_q <= '0;
    end else if (hsRise) begin
      dotCnt_q <= '0;
    end else begin
      dotCnt_q <= dotCnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lineCnt_q <= '0;
    end else if (vsRise) begin
      lineCnt_q <= '0;
    end else if (hsRise) begin
      lineCnt_q <= lineCnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Block-end detection
  // ----------------------------------------------------------------
  // Window state is not looked at, so hidden caption blocks still end
  logic [NBLK-1:0] layerHit;
  logic layerAct_d, layerAct_q, blockEndIrq_d;

  for (genvar i = 0; i < NBLK; i++) begin : gBlk
    logic [VPW-1:0] bv;
    logic [VPW:0] bEnd;
    assign bv = blkVpos[i*VPW +: VPW];
    assign bEnd = {1'b0, bv} + {5'h00, blkHeight[i*6 +: 6]};
    assign layerHit[i] = blkOn[i]
      && (lineCnt_q >= bv) && ({1'b0, lineCnt_q} < bEnd)
      && (blkLayer[i] == ctrl2[osw_pkg::CTRL2_LAYER_BIT]);
  end

  // Union of all live blocks: overlap yields a single falling edge
  assign layerAct_d = |layerHit;
  assign blockEndIrq_d = layerAct_q && !layerAct_d;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      layerAct_q <= 1'b0;
      blockEndIrq <= 1'b0;
    end else begin
      layerAct_q <= layerAct_d;
      blockEndIrq <= blockEndIrq_d;
    end
  end

  // ----------------------------------------------------------------
  // Sprites
  // ----------------------------------------------------------------
  logic [HPW-1:0] sprH [2];
  logic [VPW-1:0] sprV [2];
  logic [1:0] sprOn_d, sprOn_q, sprHit_d, sprHit_q;
  logic [3:0] sprDot [2];
  logic [1:0] sprVis;
  logic spriteIrq_d;

  assign sprH[0] = spriteHpos1;
  assign sprH[1] = spriteHpos2;
  assign sprV[0] = spriteVpos1;
  assign sprV[1] = spriteVpos2;

  for (genvar j = 0; j < 2; j++) begin : gSpr
    logic [DW-1:0] x0, sx;
    logic [VPW-1:0] sy;
    logic hitX;
    assign x0 = {sprH[j], 1'b0};
    assign sx = dotCnt_q - x0;
    assign sy = lineCnt_q - sprV[j];
    assign hitX = (dotCnt_q >= x0) && (sx < osw_pkg::SPR_W_DOTS);
    assign sprOn_d[j] = sprEnable[j] && (lineCnt_q >= sprV[j])
      && (sy < osw_pkg::SPR_H_LINES);
    assign sprHit_d[j] = sprOn_d[j] && hitX;

    osw_sprite_ram #(
      .DW(osw_pkg::SPR_DOT_BITS),
      .AW(osw_pkg::SPR_ADDR_W),
      .DEPTH(osw_pkg::SPR_DEPTH)
    ) uRam (
      .mclk(mclk),
      .resetn(resetn),
      .wrEn(sprWrEn && (sprWrSel == 1'(j))),
      .wrAddr(sprWrAddr),
      .wrData(sprWrData),
      .rdAddr({sy[osw_pkg::SPR_ROW_W-1:0], sx[osw_pkg::SPR_COL_W-1:0]}),
      .rdData_q(sprDot[j])
    );

    assign sprVis[j] = sprHit_q[j] && (sprDot[j] != osw_pkg::SPR_CLEAR_DOT);
  end

  assign spriteIrq_d = |(sprOn_q & ~sprOn_d);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sprOn_q <= '0;
      sprHit_q <= '0;
      spriteIrq <= 1'b0;
    end else begin
      sprOn_q <= sprOn_d;
      sprHit_q <= sprHit_d;
      spriteIrq <= spriteIrq_d;
    end
  end

  // ----------------------------------------------------------------
  // Window and blank
  // ----------------------------------------------------------------
  logic vFunc, hFunc, vBlankSel, hBlankSel, inV, inH;
  localparam int EDGE_SH = osw_pkg::EDGE_H_SHIFT;
  logic outsideWin, modeOk, blankArea;
  logic [DW-EDGE_SH-1:0] dotQuad;

  assign vFunc = ctrl1[osw_pkg::CTRL1_VFUNC_BIT];
  assign hFunc = ctrl2[osw_pkg::CTRL2_HFUNC_BIT];
  assign vBlankSel = ctrl2[osw_pkg::CTRL2_VBLANK_BIT];
  assign hBlankSel = ctrl2[osw_pkg::CTRL2_HBLANK_BIT];
  assign dotQuad = dotCnt_q[DW-1:EDGE_SH];
  assign inV = (lineCnt_q >= topEdgeReg) && (lineCnt_q <= bottomEdgeReg);
  assign inH = (dotQuad >= leftEdgeReg) && (dotQuad <= rightEdgeReg);
  assign outsideWin = (vFunc && !vBlankSel && !inV)
    || (hFunc && !hBlankSel && !inH);

  always_comb begin
    case (charMode)
      osw_pkg::MODE_CAPTION: modeOk = ctrl3[osw_pkg::CTRL3_CAPTION_BIT];
      osw_pkg::MODE_GENERAL: modeOk = ctrl3[osw_pkg::CTRL3_GENERAL_BIT];
      osw_pkg::MODE_DOT: modeOk = ctrl3[osw_pkg::CTRL3_DOT_BIT];
      default: modeOk = 1'b0;
    endcase
  end

  assign blankArea = ((vFunc && vBlankSel && !inV)
    || (hFunc && hBlankSel && !inH)) && !inBlanking;

  // ----------------------------------------------------------------
  // Pixel stage, aligned with the sprite RAM latency
  // ----------------------------------------------------------------
  logic charVis_q, charO2_q, blank_q, rasterOk_q;
  logic [3:0] charColor_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      charVis_q <= 1'b0;
      charO2_q <= 1'b0;
      charColor_q <= '0;
      blank_q <= 1'b0;
      rasterOk_q <= 1'b0;
    end else begin
      charVis_q <= charVis && !(outsideWin && modeOk);
      charO2_q <= charO2 && !outsideWin;
      charColor_q <= charColor;
      blank_q <= blankArea;
      rasterOk_q <= rasterColor[osw_pkg::RAS_ON_BIT] && !blankArea
        && (!inBlanking || rasterColor[osw_pkg::RAS_SYNC_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Output priority
  // ----------------------------------------------------------------
  logic pickTwo;
  logic [3:0] pixIdx, palColor, colorMux;
  logic o2Mux;

  // Tie on start line keeps sprite 1 in front
  assign pickTwo = sprVis[1] && (!sprVis[0] || (spriteVpos2 > spriteVpos1));
  assign pixIdx = pickTwo ? sprDot[1] : sprDot[0];
  assign palColor = paletteFlat[{pixIdx, 2'b00} +: osw_pkg::PAL_W];

  always_comb begin
    if (|sprVis) begin
      colorMux = palColor;
    end else if (charVis_q) begin
      colorMux = charColor_q;
    end else if (rasterOk_q) begin
      colorMux = rasterColor[osw_pkg::RAS_RED_BIT +: 4];
    end else begin
      colorMux = 4'h0;
    end
  end

  // Sprites neither drive nor mask the second overlay
  assign o2Mux = charVis_q ? charO2_q
    : (charO2_q || (rasterOk_q && rasterColor[osw_pkg::RAS_O2_BIT]));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      redOut <= 1'b0;
      greenOut <= 1'b0;
      blueOut <= 1'b0;
      blankOverlayOut <= 1'b0;
      secondOverlayOut <= 1'b0;
    end else begin
      redOut <= colorMux[0];
      greenOut <= colorMux[1];
      blueOut <= colorMux[2];
      blankOverlayOut <= colorMux[3] || blank_q;
      secondOverlayOut <= o2Mux;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blockEndPend <= 1'b0;
    end else if (blockEndIrq) begin
      blockEndPend <= 1'b1;
    end else if (blockEndClr) begin
      blockEndPend <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      spritePend <= 1'b0;
    end else if (spriteIrq) begin
      spritePend <= 1'b1;
    end else if (spriteClr) begin
      spritePend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_layerEnds;
    layerAct_q ##1 !layerAct_q;
  endsequence

  sequence s_spriteEnds;
    (|sprOn_q) ##1 (|(~sprOn_q & $past(sprOn_q)));
  endsequence

  a_block_end_irq: assert property (s_layerEnds |-> blockEndIrq)
    else $error("block end without interrupt");
  a_block_irq_once: assert property (blockEndIrq |=> !blockEndIrq)
    else $error("block end interrupt repeated");
  a_off_block_quiet: assert property (blkOn == '0 ##1 blkOn == '0
    |=> !blockEndIrq)
    else $error("interrupt from switched-off blocks");
  a_sprite_end_irq: assert property (s_spriteEnds |-> spriteIrq)
    else $error("sprite end without interrupt");
  a_pend_hold: assert property (blockEndIrq ##1 (!blockEndClr)[*2]
    |-> blockEndPend)
    else $error("block end flag lost");
  a_sprite_front: assert property ((|sprVis)
    |=> {blankOverlayOut, blueOut, greenOut, redOut}
      == ($past(palColor) | {$past(blank_q), 3'b000}))
    else $error("sprite not in front");
  a_sprite_o2: assert property ((|sprVis) && !charVis_q
    && !rasterOk_q |=> secondOverlayOut == $past(charO2_q))
    else $error("second overlay altered by sprite");
  a_sprite_tie: assert property (sprVis == 2'b11
    && spriteVpos1 == spriteVpos2 |-> pixIdx == sprDot[0])
    else $error("tie did not pick sprite 1");
  a_blank_gap: assert property (inBlanking |=> !blank_q)
    else $error("blank during blanking interval");
  a_raster_blank: assert property (blank_q && !charVis_q && !(|sprVis)
    |=> !redOut && !greenOut && !blueOut)
    else $error("raster shown in blank area");
  a_char_over_raster: assert property (charVis_q && !(|sprVis)
    |=> {blueOut, greenOut, redOut} == $past(charColor_q[2:0]))
    else $error("raster mixed into character");
endmodule : osw_top

// File: tb/osw_crt_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Video timing source seen by the overlay
// ----------------------------------------------------------------
module osw_crt_model #(
  parameter int LINE = 128,
  parameter int LINES = 32
) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Reset, low
  output logic hsyncPin, // High in line blanking
  output logic vsyncPin, // High in frame blanking
  output int dotNo, // Dot within line
  output int lineNo // Line within frame
);
  // Short frame keeps the run brief; still tall enough for a sprite
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dotNo <= 0;
      lineNo <= 0;
    end else if (dotNo == LINE - 1) begin
      dotNo <= 0;
      lineNo <= (lineNo == LINES - 1) ? 0 : lineNo + 1;
    end else begin
      dotNo <= dotNo + 1;
    end
  end

  assign hsyncPin = resetn && (dotNo < 8);
  assign vsyncPin = resetn && (lineNo < 2);
endmodule : osw_crt_model

// File: tb/osd_sprite_window_blank_raster_test.sv
`timescale 1ns/1ps
module osd_sprite_window_blank_raster_test;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  localparam int LINE = 128;
  localparam int LINES = 32;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsyncPin, vsyncPin;
  int dotNo, lineNo;
  int badCount = 0;
  int totalChecks = 0;
  logic [7:0] ctrl1 = 8'h00, ctrl2 = 8'h00, ctrl3 = 8'h00;
  logic [6:0] rasterColor = 7'h00;
  logic [9:0] topEdgeReg = 10'h000, bottomEdgeReg = 10'h000;
  logic [9:0] leftEdgeReg = 10'h000, rightEdgeReg = 10'h000;
  logic [15:0] blkOn = 16'h0000, blkLayer = 16'h0000;
  logic [159:0] blkVpos = '0;
  logic [95:0] blkHeight = '0;
  logic charVis = 1'b0, charO2 = 1'b0;
  logic [3:0] charColor = 4'h0, sprWrData = 4'h0;
  logic [1:0] charMode = 2'b00, sprEnable = 2'b00;
  logic [10:0] spriteHpos1 = 11'h014, spriteHpos2 = 11'h014;
  logic [9:0] spriteVpos1 = 10'h008, spriteVpos2 = 10'h00a;
  logic [63:0] paletteFlat;
  logic sprWrEn = 1'b0, sprWrSel = 1'b0;
  logic [9:0] sprWrAddr = 10'h000;
  logic blockEndClr = 1'b0, spriteClr = 1'b0;
  logic redOut, greenOut, blueOut, blankOverlayOut, secondOverlayOut;
  logic blockEndIrq, spriteIrq, blockEndPend, spritePend;

  always #20 mclk = ~mclk;

  osw_crt_model #(.LINE(LINE), .LINES(LINES)) crt (.mclk, .resetn,
    .hsyncPin, .vsyncPin, .dotNo, .lineNo);

  osw_top DUT (.mclk, .resetn, .hsyncPin, .vsyncPin, .ctrl1, .ctrl2,
    .ctrl3, .rasterColor, .topEdgeReg, .bottomEdgeReg, .leftEdgeReg,
    .rightEdgeReg, .blkOn, .blkLayer, .blkVpos, .blkHeight, .charVis,
    .charColor, .charO2, .charMode, .sprEnable, .spriteHpos1,
    .spriteHpos2, .spriteVpos1, .spriteVpos2, .paletteFlat, .sprWrEn,
    .sprWrSel, .sprWrAddr, .sprWrData, .blockEndClr, .spriteClr,
    .redOut, .greenOut, .blueOut, .blankOverlayOut, .secondOverlayOut,
    .blockEndIrq, .spriteIrq, .blockEndPend, .spritePend);

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick

  function automatic logic [3:0] pal(input logic [3:0] k);
    return k ^ 4'h9;
  endfunction : pal

  task automatic chk_val(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input string n, input int e, input int g);
    totalChecks++;
    if (g != e) begin
      badCount++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_cnt

  task automatic wait_at(input int l, input int d);
    for (int n = 0; n < 2 * LINE * LINES; n++) begin
      if (lineNo == l && dotNo == d) return;
      tick;
    end
    chk_cnt("scan position reached", 1, 0);
  endtask : wait_at

  task automatic pix(input int l, input int d, input logic [4:0] e);
    wait_at(l, d);
    // Sync synchroniser and pixel pipe leave the design a few dots late
    repeat (6) tick;
    chk_val("pixel", {3'h0, e}, {3'h0, secondOverlayOut,
      blankOverlayOut, blueOut, greenOut, redOut});
  endtask : pix

  task automatic count_frame(input int expB, input int expS);
    int nb;
    int ns;
    nb = 0;
    ns = 0;
    wait_at(2, 64);
    repeat (LINE * LINES) begin
      tick;
      nb += (blockEndIrq === 1'b1);
      ns += (spriteIrq === 1'b1);
    end
    chk_cnt("block-end pulses", expB, nb);
    chk_cnt("sprite pulses", expS, ns);
  endtask : count_frame

  task automatic load_sprite(input logic sel, input logic [3:0] v);
    for (int a = 0; a < 640; a++) begin
      sprWrEn = 1'b1;
      sprWrSel = sel;
      sprWrAddr = 10'(a);
      sprWrData = v;
      tick;
    end
    sprWrEn = 1'b0;
  endtask : load_sprite

  task automatic set_blk(input int i, input logic on, input logic lay,
                         input logic [9:0] v, input logic [5:0] h);
    blkOn[i] = on;
    blkLayer[i] = lay;
    blkVpos[i*10 +: 10] = v;
    blkHeight[i*6 +: 6] = h;
  endtask : set_blk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 16; k++) begin
      paletteFlat[4*k +: 4] = pal(4'(k));
    end
    repeat (8) @(posedge mclk);
    #1 resetn = 1'b1;
    tick;
    load_sprite(1'b0, 4'h5);
    load_sprite(1'b1, 4'h3);
    set_blk(0, 1'b1, 1'b0, 10'h008, 6'h04);
    sprEnable = 2'b11;
    count_frame(1, 2);
    chk_val("block flag", 8'h01, {7'h00, blockEndPend});
    chk_val("sprite flag", 8'h01, {7'h00, spritePend});
    blockEndClr = 1'b1;
    spriteClr = 1'b1;
    tick;
    blockEndClr = 1'b0;
    spriteClr = 1'b0;
    tick;
    chk_val("block flag", 8'h00, {7'h00, blockEndPend});
    chk_val("sprite flag", 8'h00, {7'h00, spritePend});
    blkLayer[0] = 1'b1;
    count_frame(0, 2);
    ctrl2 = 8'h80;
    count_frame(1, 2);
    ctrl2 = 8'h00;
    blkLayer[0] = 1'b0;
    blkOn[0] = 1'b0;
    count_frame(0, 2);
    set_blk(0, 1'b1, 1'b0, 10'h008, 6'h06);
    set_blk(1, 1'b1, 1'b0, 10'h00a, 6'h08);
    count_frame(1, 2);
    blkOn[1] = 1'b0;
    ctrl1 = 8'h21;
    ctrl3 = 8'h20;
    topEdgeReg = 10'h014;
    bottomEdgeReg = 10'h01c;
    count_frame(1, 2);
    ctrl1 = 8'h00;
    ctrl3 = 8'h00;
    charVis = 1'b1;
    charColor = 4'h3;
    charO2 = 1'b1;
    pix(16, 56, {1'b1, pal(4'h3)});
    spriteVpos2 = 10'h008;
    pix(18, 56, {1'b1, pal(4'h5)});
    rasterColor = 7'h5f;
    pix(18, 100, 5'h13);
    charVis = 1'b0;
    charO2 = 1'b0;
    pix(19, 100, 5'h1f);
    rasterColor = 7'h4a;
    pix(20, 100, 5'h0a);
    pix(21, 3, 5'h00);
    rasterColor = 7'h6a;
    pix(22, 3, 5'h0a);
    rasterColor = 7'h00;
    charVis = 1'b1;
    charO2 = 1'b1;
    ctrl1 = 8'h21;
    ctrl3 = 8'h20;
    pix(16, 56, {1'b0, pal(4'h5)});
    pix(16, 100, 5'h00);
    charMode = 2'b01;
    pix(17, 100, 5'h03);
    charMode = 2'b10;
    ctrl3 = 8'ha0;
    pix(18, 100, 5'h00);
    pix(24, 100, 5'h13);
    sprEnable = 2'b00;
    ctrl1 = 8'h20;
    ctrl2 = 8'h40;
    ctrl3 = 8'h00;
    topEdgeReg = 10'h00c;
    bottomEdgeReg = 10'h016;
    charO2 = 1'b0;
    charColor = 4'h1;
    pix(1, 100, 5'h01);
    pix(5, 100, 5'h09);
    charVis = 1'b0;
    rasterColor = 7'h47;
    pix(6, 100, 5'h08);
    pix(16, 100, 5'h07);
    rasterColor = 7'h00;
    ctrl1 = 8'h00;
    ctrl2 = 8'h30;
    leftEdgeReg = 10'h006;
    rightEdgeReg = 10'h019;
    pix(16, 3, 5'h00);
    pix(16, 12, 5'h08);
    pix(16, 90, 5'h00);
    ctrl1 = 8'h01;
    ctrl2 = 8'h10;
    ctrl3 = 8'h80;
    charVis = 1'b1;
    charColor = 4'h1;
    pix(17, 12, 5'h00);
    pix(17, 90, 5'h01);
    print_verdict;
  end

  // A stuck scan would otherwise hang the run
  initial begin
    repeat (100000) @(posedge mclk);
    badCount++;
    print_verdict;
  end
endmodule : osd_sprite_window_blank_raster_test
